// ### rtl/ldsl_core.sv
// Purpose: Serial load, status readback, PWM and error flag logic of a 16-channel LED driver
// Assumes: Serial shift clock is a separate domain; host keeps MSB-first order
// Notes:   Analog current set is reduced to the per-channel dot correction outputs
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// Summary of operation
// - Each rising shift clock edge shifts serial_in into the shift register.
// - Load strobe rising edge copies shift register into internal registers.
// - Bit leaving the shift register end drives serial_out.
// - Mode low makes the shift register 192 bits long.
// - Load updates greyscale when mode low, dot correction when high.
// - Dot correction packet is 96 bits, sixteen 6-bit words.
// - Greyscale packet is 192 bits, sixteen 12-bit words, loaded together.
// - All dot correction values change together on one load.
// - After greyscale load the shift register holds the status packet.
// - Status packet carries per-channel open-LED flags.
// - Error output released with no error, pulled low on error.
// - Output disable high masks open-LED flags from the error output.
// - Thermal error flag above 150 C shows in status and pulls error low, except with output disable and mode both high.
// - Separate thermal warning flag at 125 C.
// - Open-LED flagged when output low 1 us after channel switches on.
// - Output disable high forces all channels off.
// - Output disable high resets the PWM counter.
// - Power-up in greyscale mode with shift registers cleared.
// - Power-up dot correction 63, greyscale 4095 for every channel.
// - Dot correction scales channel current linearly in 64 steps.
// - Greyscale value v above 1 sets on-time to v-1 steps of the 4096-step count; value 1 never turns off.
// - Status: open bits 191:176 and 31:16, error 175, warning 174, readback 167:72.
// - First PWM step turns on nonzero channels; off when counter reaches the value minus 1.
module ldsl_core (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         shift_clk,
    input  wire logic         serial_in,
    input  wire logic         load_strobe,
    input  wire logic         mode_dc,
    input  wire logic         output_disable,
    input  wire logic         pwm_count_clock,
    input  wire logic         temp_over_error,
    input  wire logic         temp_over_warning,
    input  wire logic [15:0]  low_sense,
    output logic              serial_out,
    output logic              error_flag_n_o,
    output logic              error_flag_n_oe,
    output logic [15:0]       channel_output,
    output logic [95:0]       dot_corr_value
);
    localparam int N  = ldsl_pkg::NUM_CH;
    localparam int GW = ldsl_pkg::GS_PKT_W;
    localparam int DW = ldsl_pkg::DC_PKT_W;

    // ---------------------------------------------------------------
    // Synchronised control pins
    // ---------------------------------------------------------------
    logic        load_s;
    logic        mode_s;
    logic        dis_s;
    logic        gclk_s;
    logic        load_q;
    logic        gclk_q;
    logic        dis_q;
    logic        load_rise;
    logic        gclk_rise;
    ldsl_pkg::ldsl_therm_t therm_s;

    ldsl_sync #(.W(4)) u_sync_ctl (
        .clk (clk),
        .d   ({load_strobe, mode_dc, output_disable, pwm_count_clock}),
        .q   ({load_s, mode_s, dis_s, gclk_s})
    );
    ldsl_sync #(.W(2)) u_sync_therm (
        .clk (clk),
        .d   ({temp_over_error, temp_over_warning}),
        .q   (therm_s)
    );

    // Edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            load_q <= 1'b0;
            gclk_q <= 1'b0;
            dis_q  <= 1'b1;
        end else begin
            load_q <= load_s;
            gclk_q <= gclk_s;
            dis_q  <= dis_s;
        end
    end
    assign load_rise = load_s && !load_q;
    assign gclk_rise = gclk_s && !gclk_q;

    // ---------------------------------------------------------------
    // Shift register, shift clock domain
    // ---------------------------------------------------------------
    logic [GW-1:0] shreg_q;
    logic          shift_rst_q;
    logic          sid_tog_q;
    logic [2:0]    sid_sync_q;
    logic [GW-1:0] sid_word_q;
    logic          sh_mode_m;
    logic          sh_mode_s;
    logic          sh_rst_m;
    logic          sh_rst_s;

    // Mode and reset cross into shift domain
    always_ff @(posedge shift_clk) begin
        sh_mode_m <= mode_dc;
        sh_mode_s <= sh_mode_m;
        sh_rst_m  <= rst;
        sh_rst_s  <= sh_rst_m;
    end

    // Status word capture request from core, carried by toggle
    always_ff @(posedge shift_clk) begin
        sid_sync_q <= {sid_sync_q[1:0], sid_tog_q};
    end

    // Shift MSB first; status load replaces the contents
    always_ff @(posedge shift_clk) begin
        if (sh_rst_s) begin
            shreg_q <= '0;
        end else if (sid_sync_q[2] != sid_sync_q[1]) begin
            shreg_q <= {sid_word_q[GW-2:0], serial_in};
        end else begin
            shreg_q <= {shreg_q[GW-2:0], serial_in};
        end
    end

    // Bit leaving the active end; 96-bit length in dot correction mode
    assign serial_out = sh_mode_s ? shreg_q[DW-1] : shreg_q[GW-1];

    // ---------------------------------------------------------------
    // Latching on load strobe, core domain
    // ---------------------------------------------------------------
    logic [GW-1:0] grey_q;
    logic [DW-1:0] dc_q;
    logic [N-1:0]  open_q;
    logic [N-1:0]  open_hit;
    logic          load_arm_q;

    // Load waits one cycle so the shift register has settled
    always_ff @(posedge clk) begin
        if (rst) begin
            load_arm_q <= 1'b0;
        end else begin
            load_arm_q <= load_rise;
        end
    end

    // Host keeps shift clock still around load strobe, so the word is stable
    always_ff @(posedge clk) begin
        if (rst) begin
            grey_q <= {N{ldsl_pkg::GS_RESET}};
            dc_q   <= {N{ldsl_pkg::DC_RESET}};
        end else if (load_arm_q) begin
            if (mode_s) begin
                dc_q   <= shreg_q[DW-1:0];
            end else begin
                grey_q <= shreg_q;
            end
        end
    end

    // Status word built and handed over after greyscale load
    always_ff @(posedge clk) begin
        if (rst) begin
            sid_tog_q  <= 1'b0;
            sid_word_q <= '0;
        end else if (load_arm_q && !mode_s) begin
            sid_word_q <= '0;
            sid_word_q[GW-1:ldsl_pkg::SP_OPEN_HI]     <= open_q;
            sid_word_q[ldsl_pkg::SP_TEF]              <= therm_s.thermal_error_flag;
            sid_word_q[ldsl_pkg::SP_TWF]              <= therm_s.thermal_warning_flag;
            sid_word_q[ldsl_pkg::SP_DC_LO+DW-1:ldsl_pkg::SP_DC_LO] <= dc_q;
            sid_word_q[ldsl_pkg::SP_OPEN_LO+N-1:ldsl_pkg::SP_OPEN_LO] <= open_q;
            sid_tog_q  <= ~sid_tog_q;
        end
    end

    assign dot_corr_value = dc_q; // Drives 64-step current DAC per channel

    // ---------------------------------------------------------------
    // PWM counter
    // ---------------------------------------------------------------
    logic [11:0] count_q;
    logic [N-1:0] chan_on;

    // Cleared while disabled, advances on each count clock rising edge
    always_ff @(posedge clk) begin
        if (rst || dis_s) begin
            count_q <= 12'h000;
        end else if (gclk_rise) begin
            count_q <= count_q + 12'h001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            ldsl_pwm_chan u_chan (
                .clk        (clk),
                .rst        (rst),
                .step       (gclk_rise),
                .restart    (dis_s),
                .count      (count_q),
                .grey_value (grey_q[g*ldsl_pkg::GS_W +: ldsl_pkg::GS_W]),
                .low_sense  (low_sense[g]),
                .chan_on    (chan_on[g]),
                .open_hit   (open_hit[g])
            );
        end
    endgenerate

    // Outputs forced off while disabled or dot correction zero
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_output <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                channel_output[i] <= chan_on[i] && !dis_s
                    && (dc_q[i*ldsl_pkg::DC_W +: ldsl_pkg::DC_W] != 6'h00);
            end
        end
    end

    // Open flags sticky until next greyscale load; set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            open_q <= '0;
        end else begin
            open_q <= ((load_arm_q && !mode_s) ? '0 : open_q) | open_hit;
        end
    end

    // ---------------------------------------------------------------
    // Error output, open drain
    // ---------------------------------------------------------------
    logic err_any;
    always_comb begin
        if (!dis_s) begin
            err_any = therm_s.thermal_error_flag || (|open_q);
        end else if (mode_s) begin
            err_any = therm_s.thermal_warning_flag;
        end else begin
            err_any = therm_s.thermal_error_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            error_flag_n_oe <= 1'b0;
        end else begin
            error_flag_n_oe <= err_any;
        end
    end
    assign error_flag_n_o = 1'b0;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    err_mask_a: assert property (@(posedge clk) disable iff (rst)
        (dis_s && !mode_s && !therm_s.thermal_error_flag) |=> !error_flag_n_oe)
        else $error("open flag not masked");
    err_drive_a: assert property (@(posedge clk) disable iff (rst)
        (!dis_s && (|open_q)) |=> error_flag_n_oe)
        else $error("error output not pulled");
    warn_sel_a: assert property (@(posedge clk) disable iff (rst)
        (dis_s && mode_s) |=> (error_flag_n_oe == $past(therm_s.thermal_warning_flag)))
        else $error("warning not shown");
    out_off_a: assert property (@(posedge clk) disable iff (rst)
        dis_s |=> (channel_output == '0))
        else $error("outputs not off");
    cnt_clear_a: assert property (@(posedge clk) disable iff (rst)
        dis_s |=> (count_q == 12'h000))
        else $error("counter not cleared");
    dc_load_a: assert property (@(posedge clk) disable iff (rst)
        (load_arm_q && mode_s) |=> (dc_q == $past(shreg_q[DW-1:0])))
        else $error("dot correction not loaded");
    gs_keep_a: assert property (@(posedge clk) disable iff (rst)
        (load_arm_q && mode_s) |=> $stable(grey_q))
        else $error("greyscale changed in dc mode");
    sid_tog_a: assert property (@(posedge clk) disable iff (rst)
        (load_arm_q && !mode_s) |=> (sid_tog_q != $past(sid_tog_q)))
        else $error("status hand-over missing");
endmodule // ldsl_core
`default_nettype wire

// ### rtl/ldsl_pkg.sv
// Purpose: Shared constants and types for the LED driver serial load and error logic
// Assumes: 16 channels, 6-bit dot correction, 12-bit greyscale
// Notes:   Status packet bit positions live here
package ldsl_pkg;
    localparam int NUM_CH      = 16;
    localparam int DC_W        = 6;
    localparam int GS_W        = 12;
    localparam int DC_PKT_W    = 96;
    localparam int GS_PKT_W    = 192;
    // Status packet layout
    localparam int SP_OPEN_HI  = 176;
    localparam int SP_TEF      = 175;
    localparam int SP_TWF      = 174;
    localparam int SP_DC_LO    = 72;
    localparam int SP_OPEN_LO  = 16;
    // Power-up defaults
    localparam logic [5:0]  DC_RESET = 6'h3f;
    localparam logic [11:0] GS_RESET = 12'hfff;
    // Open detection sample delay
    localparam int OPEN_DLY_NS = 1000;
    localparam int CLK_NS      = 100;
    localparam int OPEN_DLY_CYC = (OPEN_DLY_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic thermal_error_flag;
        logic thermal_warning_flag;
    } ldsl_therm_t;
endpackage
`default_nettype wire

// ### rtl/ldsl_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level from another domain
// Notes:   First stage read only by second
`timescale 1ns/1ns
`default_nettype none
module ldsl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Two stages
    always_ff @(posedge clk) begin
        meta_q <= d;
        q      <= meta_q;
    end
endmodule // ldsl_sync
`default_nettype wire

// ### rtl/ldsl_pwm_chan.sv
// Purpose: Per-channel PWM compare and open detection sampling
// Assumes: Counter and enable come from the core clock domain
// Notes:   One instance per channel
`timescale 1ns/1ns
`default_nettype none
module ldsl_pwm_chan (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        step,
    input  wire logic        restart,
    input  wire logic [11:0] count,
    input  wire logic [11:0] grey_value,
    input  wire logic        low_sense,
    output logic             chan_on,
    output logic             open_hit
);
    logic [3:0] on_cnt_q;

    // Switch on at first step when nonzero, off when count plus one matches
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            chan_on <= 1'b0;
        end else if (step) begin
            if (count == 12'h000) begin
                chan_on <= (grey_value != 12'h000);
            end else if (count + 12'h001 == grey_value) begin
                chan_on <= 1'b0;
            end
        end
    end

    // Sample the output 1 us after it switches on
    always_ff @(posedge clk) begin
        if (rst || !chan_on) begin
            on_cnt_q <= 4'h0;
            open_hit <= 1'b0;
        end else begin
            if (on_cnt_q != 4'(ldsl_pkg::OPEN_DLY_CYC)) begin
                on_cnt_q <= on_cnt_q + 4'h1;
            end
            open_hit <= (on_cnt_q == 4'(ldsl_pkg::OPEN_DLY_CYC - 1)) && low_sense;
        end
    end
endmodule // ldsl_pwm_chan
`default_nettype wire

// ### testbench/ldsl_host.sv
// Purpose: Host model that drives the serial chain of the LED driver
// Assumes: Shift clock period 125 ns, idle low outside frames
// Notes:   A released data line shows the inverse of the last bit sent
`timescale 1ns/1ns
`default_nettype none
module ldsl_host (
    input  wire logic clk,
    input  wire logic serial_out,
    output logic      shift_clk,
    output logic      serial_in,
    output logic      load_strobe,
    output logic      mode_dc
);
    // ---------------------------------------------------------------
    // Idle levels
    // ---------------------------------------------------------------
    initial begin
        shift_clk   = 1'b0;
        serial_in   = 1'b0;
        load_strobe = 1'b0;
        mode_dc     = 1'b0;
    end

    // Bare shift edges, used while reset holds and just after its release
    task automatic run_edges(input int n);
        repeat (n) begin
            #63 shift_clk = 1'b1;
            #62 shift_clk = 1'b0;
        end
    endtask

    // Mode change just after a core edge, before a frame
    task automatic set_mode(input logic m);
        @(posedge clk);
        #5 mode_dc = m;
    endtask

    // Frame of n bits, top bit first; rd keeps serial_out after each edge
    task automatic shift(input logic [191:0] d, input int n, output logic [191:0] rd);
        rd = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = d[i];
            #63 shift_clk = 1'b1;
            #62 rd[i] = serial_out;
            shift_clk = 1'b0;
        end
        serial_in = ~serial_in;
    endtask

    // Load strobe held three core cycles, shift clock quiet meanwhile
    task automatic load();
        @(posedge clk);
        #5 load_strobe = 1'b1;
        repeat (3) @(posedge clk);
        #5 load_strobe = 1'b0;
        repeat (10) @(posedge clk);
    endtask
endmodule // ldsl_host
`default_nettype wire

// ### testbench/ldsl_core_test.sv
// Purpose: Self-checking bench for the LED driver serial load and error logic
// Assumes: Core clock 100 ns, host model drives the serial side
// Notes:   Status loads on the third shift edge after a greyscale load; bit j lands in rd[j-1]
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(name, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("[FAIL] %s expected %h seen %h", name, exp, got); \
        end \
    end
module ldsl_core_test;
    logic         clk = 1'b0;
    logic         rst;
    logic         output_disable;
    logic         pwm_count_clock;
    logic         temp_over_error;
    logic         temp_over_warning;
    logic [15:0]  low_sense;
    logic         shift_clk;
    logic         serial_in;
    logic         load_strobe;
    logic         mode_dc;
    logic         serial_out;
    logic         error_flag_n_o;
    logic         error_flag_n_oe;
    logic [15:0]  channel_output;
    logic [95:0]  dot_corr_value;
    logic [95:0]  dcp;
    logic [191:0] gsp;
    logic [191:0] rd;
    logic [4:0]   etab [6] = '{5'h00, 5'h11, 5'h15, 5'h0c, 5'h0f, 5'h16};
    int           fail_count = 0;
    int           n_checks = 0;

    // ---------------------------------------------------------------
    // Clock and instances
    // ---------------------------------------------------------------
    always #50 clk = ~clk;

    ldsl_core i_ldsl_core (
        .clk(clk), .rst(rst), .shift_clk(shift_clk), .serial_in(serial_in),
        .load_strobe(load_strobe), .mode_dc(mode_dc), .output_disable(output_disable),
        .pwm_count_clock(pwm_count_clock), .temp_over_error(temp_over_error),
        .temp_over_warning(temp_over_warning), .low_sense(low_sense),
        .serial_out(serial_out), .error_flag_n_o(error_flag_n_o),
        .error_flag_n_oe(error_flag_n_oe), .channel_output(channel_output),
        .dot_corr_value(dot_corr_value)
    );

    ldsl_host i_ldsl_host (
        .clk(clk), .serial_out(serial_out), .shift_clk(shift_clk),
        .serial_in(serial_in), .load_strobe(load_strobe), .mode_dc(mode_dc)
    );

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    // One count clock pulse, long enough for the synchroniser
    task automatic pwm_pulse();
        pwm_count_clock = 1'b1;
        step(4);
        pwm_count_clock = 1'b0;
        step(4);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #2000000;
        fail_count++;
        $display("[FAIL] watchdog expected end seen hang");
        end_sim();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        output_disable = 1'b0;
        pwm_count_clock = 1'b0;
        temp_over_error = 1'b0;
        temp_over_warning = 1'b0;
        low_sense = '0;
        i_ldsl_host.run_edges(4);
        step(2);
        rst = 1'b0;
        // Shift-domain reset copy only clears on shift edges after release
        i_ldsl_host.run_edges(3);
        step(4);
        `CHECK_EQ("dc_reset", {16{6'h3f}}, dot_corr_value)
        `CHECK_EQ("err_level", 1'b0, error_flag_n_o)
        pwm_pulse();
        `CHECK_EQ("ch_default", 16'hffff, channel_output)
        output_disable = 1'b1;
        step(6);
        `CHECK_EQ("ch_off", 16'h0000, channel_output)
        // Dot correction packet with a distinct word per channel; greyscale 0, 2, 3, then fff
        for (int i = 0; i < 16; i++) begin
            dcp[i*6 +: 6] = 6'(i * 4 + 3);
            gsp[i*12 +: 12] = (i == 0) ? 12'h000 : (i == 1) ? 12'h002 :
                              (i == 2) ? 12'h003 : 12'hfff;
        end
        i_ldsl_host.set_mode(1'b1);
        i_ldsl_host.shift({96'h0, dcp}, 96, rd);
        i_ldsl_host.load();
        `CHECK_EQ("dc_load", dcp, dot_corr_value)
        // Greyscale load, then read the status back
        temp_over_error = 1'b1;
        i_ldsl_host.set_mode(1'b0);
        i_ldsl_host.shift(gsp, 192, rd);
        i_ldsl_host.load();
        `CHECK_EQ("dc_kept", dcp, dot_corr_value)
        i_ldsl_host.shift(gsp, 192, rd);
        `CHECK_EQ("sp_dc", dcp, rd[166:71])
        `CHECK_EQ("sp_tef", 1'b1, rd[174])
        `CHECK_EQ("sp_twf", 1'b0, rd[173])
        // Error pin table: error, warning, disable, mode, expected pull
        for (int k = 0; k < 6; k++) begin
            {temp_over_error, temp_over_warning, output_disable} = etab[k][4:2];
            i_ldsl_host.set_mode(etab[k][1]);
            step(6);
            `CHECK_EQ("err_oe", etab[k][0], error_flag_n_oe)
        end
        temp_over_error = 1'b0;
        i_ldsl_host.set_mode(1'b0);
        // PWM steps against the loaded grey values
        output_disable = 1'b0;
        step(4);
        pwm_pulse();
        `CHECK_EQ("pwm_1", 16'hfffe, channel_output)
        pwm_pulse();
        `CHECK_EQ("pwm_2", 16'hfffc, channel_output)
        pwm_pulse();
        `CHECK_EQ("pwm_3", 16'hfff8, channel_output)
        output_disable = 1'b1;
        step(6);
        `CHECK_EQ("pwm_off", 16'h0000, channel_output)
        // Counter restarts; one channel reads low while on
        low_sense[5] = 1'b1;
        output_disable = 1'b0;
        step(4);
        pwm_pulse();
        `CHECK_EQ("pwm_restart", 16'hfffe, channel_output)
        step(15);
        `CHECK_EQ("open_oe", 1'b1, error_flag_n_oe)
        output_disable = 1'b1;
        step(6);
        `CHECK_EQ("open_masked", 1'b0, error_flag_n_oe)
        end_sim();
    end
endmodule // ldsl_core_test
`default_nettype wire
